//--- spmb_top.sv
// spmb_top: byte-wide parallel slave port mailbox between a master and the processor
// assumes: master pins are asynchronous and synchronised here; processor side on i_clk
`timescale 1ns/1ps
`default_nettype none
module spmb_top
	import spmb_pkg::*;
#(
	parameter int NCHAN = SPMB_NUM_CHAN
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic [7:0] i_port_data,
	output logic      [7:0] o_port_data,
	output logic            o_port_data_oe_b,
	input  wire logic       i_port_select_n,
	input  wire logic       i_port_select_alt_n,
	input  wire logic       i_port_write_strobe_n,
	input  wire logic       i_port_read_strobe_n,
	input  wire logic       i_reg_addr_bit0,
	input  wire logic       i_reg_addr_bit1,
	output logic            o_attention_pin_n,
	input  wire logic       i_cpu_wr,
	input  wire logic       i_cpu_rd,
	input  wire logic [7:0] i_cpu_addr,
	input  wire logic [7:0] i_cpu_wdata,
	output logic      [7:0] o_cpu_rdata,
	input  wire logic       i_handler_set,
	input  wire logic [7:0] i_handler_chan,
	input  wire logic       i_handler_en,
	output logic            o_cmd_pending,
	output logic            o_cmd_dispatch,
	output logic            o_cmd_unhandled,
	output logic            o_attention_out_n
);
	import spmb_pkg::*;

	// pin group: data(8), cs, cs_alt, wr, rd, a1, a0
	localparam int PW = 14;
	logic [PW-1:0] pins_s;
	logic [PW-1:0] pins_rst;
	assign pins_rst = {SPMB_BYTE_RST, // data
	                   1'b1, 1'b1,    // selects idle
	                   1'b1, 1'b1,    // strobes idle
	                   2'h0};         // address

	// every pin the master drives passes two flip-flops first
	// data rides the same two flops as the strobes, so it never runs ahead of them
	spmb_sync #(.W(PW)) u_sync (
		.i_clk     (i_clk),
		.i_rst_b   (i_rst_b),
		.i_async   ({i_port_data, i_port_select_n, i_port_select_alt_n,
		             i_port_write_strobe_n, i_port_read_strobe_n,
		             i_reg_addr_bit1, i_reg_addr_bit0}),
		.i_rst_val (pins_rst),
		.o_sync    (pins_s)
	);

	wire [7:0] m_data  = pins_s[13:6];
	wire       m_cs_n  = pins_s[5];
	wire       m_csa_n = pins_s[4];
	wire       m_wr_n  = pins_s[3];
	wire       m_rd_n  = pins_s[2];
	wire [1:0] m_addr  = pins_s[1:0];

	// either select qualifies an access
	wire m_sel   = !m_cs_n || !m_csa_n;
	wire m_wr_on = m_sel && !m_wr_n;
	wire m_rd_on = m_sel && !m_rd_n;

	spmb_cyc_t cyc_r;
	spmb_cyc_t cyc_nxt;
	logic [1:0] cyc_addr_r;
	logic [1:0] cyc_addr_nxt;
	logic [7:0] cyc_data_r;
	logic [7:0] cyc_data_nxt;

	// master-written bytes, kept apart from master-read bytes
	logic [7:0] cmd_in_r;
	logic [7:0] chan_in_r;
	logic [7:0] data_in_r;
	logic [7:0] resp_out_r;
	logic [7:0] data_out_r;
	logic [3:0] upd_r;
	logic [3:0] upd_nxt;
	logic       pending_r;
	logic       pending_nxt;

	// write commits at strobe release so data is settled; the byte kept is
	// the last one seen with the strobe low, so a master must hold data that long
	// a write seen together with a read wins and the read is dropped
	wire m_wr_done = (cyc_r == SPMB_ST_WR) && !m_wr_on;
	wire m_rd_start = (cyc_r == SPMB_ST_IDLE) && m_rd_on && !m_wr_on;

	always_comb
	begin
		cyc_nxt      = cyc_r;
		cyc_addr_nxt = cyc_addr_r;
		cyc_data_nxt = cyc_data_r;
		case (cyc_r)
			SPMB_ST_IDLE:
			begin
				if (m_wr_on)
				begin
					cyc_nxt      = SPMB_ST_WR;
					cyc_addr_nxt = m_addr;
					cyc_data_nxt = m_data;
				end
				else if (m_rd_on)
				begin
					cyc_nxt      = SPMB_ST_RD;
					cyc_addr_nxt = m_addr;
				end
			end
			SPMB_ST_WR:
			begin
				cyc_data_nxt = m_data;
				if (!m_wr_on)
					cyc_nxt = SPMB_ST_IDLE;
				else
					cyc_addr_nxt = m_addr;
			end
			SPMB_ST_RD:
			begin
				if (!m_rd_on)
					cyc_nxt = SPMB_ST_IDLE;
				else
					cyc_addr_nxt = m_addr;
			end
			default:
				cyc_nxt = SPMB_ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			cyc_r      <= SPMB_ST_IDLE;
			cyc_addr_r <= 2'h0;
			cyc_data_r <= SPMB_BYTE_RST;
		end
		else
		begin
			cyc_r      <= cyc_nxt;
			cyc_addr_r <= cyc_addr_nxt;
			cyc_data_r <= cyc_data_nxt;
		end
	end

	// master address n lands on internal location 0x20 + n
	function automatic logic [7:0] loc_of(input logic [1:0] a);
		logic [7:0] loc;
		loc = SPMB_LOC_STATUS;
		if (a == SPMB_ADDR_CMD)
			loc = SPMB_LOC_CMD;
		else if (a == SPMB_ADDR_CHAN)
			loc = SPMB_LOC_CHAN;
		else if (a == SPMB_ADDR_DATA)
			loc = SPMB_LOC_DATA;
		return loc;
	endfunction

	// one flag per port register; locations outside the four hit nothing.
	// the status register shares index 3 with its response flag
	function automatic logic [3:0] reg_hit(input logic [7:0] loc);
		logic [3:0] hit;
		hit = 4'h0;
		if (loc == SPMB_LOC_CMD)
			hit[SPMB_BIT_CMD] = 1'b1;
		else if (loc == SPMB_LOC_CHAN)
			hit[SPMB_BIT_CHAN] = 1'b1;
		else if (loc == SPMB_LOC_DATA)
			hit[SPMB_BIT_DATA] = 1'b1;
		else if (loc == SPMB_LOC_STATUS)
			hit[SPMB_BIT_RESP] = 1'b1;
		return hit;
	endfunction

	// master-side register writes
	wire [3:0] mw_hit = reg_hit(loc_of(cyc_addr_r));
	wire mw_cmd  = m_wr_done && mw_hit[SPMB_BIT_CMD];
	wire mw_chan = m_wr_done && mw_hit[SPMB_BIT_CHAN];
	wire mw_data = m_wr_done && mw_hit[SPMB_BIT_DATA];
	wire mw_stat = m_wr_done && mw_hit[SPMB_BIT_RESP];

	// processor-side writes reach only the master-readable bytes
	wire [3:0] c_hit  = reg_hit(i_cpu_addr);
	wire cw_resp = i_cpu_wr && c_hit[SPMB_BIT_CMD];
	wire cw_data = i_cpu_wr && c_hit[SPMB_BIT_DATA];
	wire cr_cmd  = i_cpu_rd && c_hit[SPMB_BIT_CMD];

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			cmd_in_r   <= SPMB_BYTE_RST;
			chan_in_r  <= SPMB_BYTE_RST;
			data_in_r  <= SPMB_BYTE_RST;
			resp_out_r <= SPMB_BYTE_RST;
			data_out_r <= SPMB_BYTE_RST;
		end
		else
		begin
			if (mw_cmd)
				cmd_in_r <= cyc_data_r;
			if (mw_chan)
				chan_in_r <= cyc_data_r;
			if (mw_data)
				data_in_r <= cyc_data_r;
			if (cw_resp)
				resp_out_r <= i_cpu_wdata;
			if (cw_data)
				data_out_r <= i_cpu_wdata;
		end
	end

	// update flags: bits 0..2 mark master writes, bit 3 the slave response.
	// a response landing with the clearing write wins, so it is never lost
	always_comb
	begin
		upd_nxt = upd_r;
		if (cr_cmd)
			upd_nxt[SPMB_BIT_CMD] = 1'b0;
		if (mw_stat)
			upd_nxt[SPMB_BIT_RESP] = 1'b0;
		if (mw_cmd)
			upd_nxt[SPMB_BIT_CMD] = 1'b1;
		if (mw_chan)
			upd_nxt[SPMB_BIT_CHAN] = 1'b1;
		if (mw_data)
			upd_nxt[SPMB_BIT_DATA] = 1'b1;
		if (cw_resp)
			upd_nxt[SPMB_BIT_RESP] = 1'b1;
	end

	// a command is pending from its arrival until the processor answers
	// pending is the poll view; the dispatch pulses stand in for an interrupt
	always_comb
	begin
		pending_nxt = pending_r;
		if (cw_resp)
			pending_nxt = 1'b0;
		if (mw_cmd)
			pending_nxt = 1'b1;
	end

	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			upd_r     <= 4'h0;
			pending_r <= 1'b0;
		end
		else
		begin
			upd_r     <= upd_nxt;
			pending_r <= pending_nxt;
		end
	end

	// channel handler table decides dispatch; it is read at commit time, so
	// an entry changed while a command is in flight decides that command
	logic chan_ok;
	spmb_chan_map #(.NCHAN(NCHAN)) u_map (
		.i_clk      (i_clk),
		.i_rst_b    (i_rst_b),
		.i_set      (i_handler_set),
		.i_set_chan (i_handler_chan),
		.i_set_val  (i_handler_en),
		.i_chan     (chan_in_r),
		.o_valid    (chan_ok)
	);

	// master read mux; address 1 has no defined use and reads zero
	// a master read never clears a flag
	wire [7:0] status_byte = {4'h0, upd_r};
	wire [7:0] m_rd_mux =
		(m_addr == SPMB_ADDR_CMD)    ? resp_out_r :
		(m_addr == SPMB_ADDR_DATA)   ? data_out_r :
		(m_addr == SPMB_ADDR_STATUS) ? status_byte :
		SPMB_BYTE_RST;

	// processor read mux for the internal locations
	wire [7:0] c_rd_mux =
		(i_cpu_addr == SPMB_LOC_CMD)    ? cmd_in_r :
		(i_cpu_addr == SPMB_LOC_CHAN)   ? chan_in_r :
		(i_cpu_addr == SPMB_LOC_DATA)   ? data_in_r :
		(i_cpu_addr == SPMB_LOC_STATUS) ? status_byte :
		SPMB_BYTE_RST;

	// all outputs registered
	// read data trails the address pins by three clocks, so a master
	// must hold the read strobe at least that long before sampling
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			o_port_data       <= SPMB_BYTE_RST;
			o_port_data_oe_b  <= 1'b1;
			o_attention_pin_n <= 1'b1;
			o_attention_out_n <= 1'b1;
			o_cpu_rdata       <= SPMB_BYTE_RST;
			o_cmd_pending     <= 1'b0;
			o_cmd_dispatch    <= 1'b0;
			o_cmd_unhandled   <= 1'b0;
		end
		else
		begin
			// bus is driven only while a read cycle is active (drive stays three clocks late)
			o_port_data       <= m_rd_mux;
			o_port_data_oe_b  <= !(m_rd_start || ((cyc_r == SPMB_ST_RD) && m_rd_on));
			o_attention_pin_n <= !upd_nxt[SPMB_BIT_RESP];
			o_attention_out_n <= !upd_nxt[SPMB_BIT_RESP];
			o_cpu_rdata       <= c_rd_mux;
			o_cmd_pending     <= pending_nxt;
			o_cmd_dispatch    <= mw_cmd && chan_ok;
			o_cmd_unhandled   <= mw_cmd && !chan_ok;
		end
	end
endmodule
`default_nettype wire

//--- spmb_pkg.sv
// spmb_pkg: constants for the slave port mailbox
// assumes: a single 25 MHz clock domain shared by all design files
package spmb_pkg;
	localparam logic [1:0] SPMB_ADDR_CMD    = 2'h0;
	localparam logic [1:0] SPMB_ADDR_CHAN   = 2'h1;
	localparam logic [1:0] SPMB_ADDR_DATA   = 2'h2;
	localparam logic [1:0] SPMB_ADDR_STATUS = 2'h3;
	localparam logic [7:0] SPMB_LOC_CMD     = 8'h20;
	localparam logic [7:0] SPMB_LOC_CHAN    = 8'h21;
	localparam logic [7:0] SPMB_LOC_DATA    = 8'h22;
	localparam logic [7:0] SPMB_LOC_STATUS  = 8'h23;
	localparam int         SPMB_BIT_CMD     = 0;
	localparam int         SPMB_BIT_CHAN    = 1;
	localparam int         SPMB_BIT_DATA    = 2;
	localparam int         SPMB_BIT_RESP    = 3;
	localparam logic [7:0] SPMB_BYTE_RST    = 8'h00;
	localparam int         SPMB_NUM_CHAN    = 256;
	typedef enum logic [2:0] {
		SPMB_ST_IDLE = 3'b001,
		SPMB_ST_WR   = 3'b010,
		SPMB_ST_RD   = 3'b100
	} spmb_cyc_t;
endpackage

//--- spmb_sync.sv
// spmb_sync: two-flop synchroniser for a group of pin inputs
// assumes: inputs are asynchronous to i_clk
`timescale 1ns/1ps
`default_nettype none
module spmb_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	input  wire logic [W-1:0] i_async,
	input  wire logic [W-1:0] i_rst_val,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_r;
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
		begin
			meta_r <= i_rst_val;
			o_sync <= i_rst_val;
		end
		else
		begin
			meta_r <= i_async;
			o_sync <= meta_r;
		end
	end
endmodule
`default_nettype wire

//--- spmb_chan_map.sv
// spmb_chan_map: table of channels that have a handler configured
// assumes: written from the slave side, same clock as the mailbox
`timescale 1ns/1ps
`default_nettype none
module spmb_chan_map #(
	parameter int NCHAN = 256
) (
	input  wire logic       i_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_set,
	input  wire logic [7:0] i_set_chan,
	input  wire logic       i_set_val,
	input  wire logic [7:0] i_chan,
	output logic            o_valid
);
	logic [NCHAN-1:0] map_r;
	assign o_valid = (32'(i_chan) < NCHAN) && map_r[i_chan];
	always_ff @(posedge i_clk)
	begin
		if (!i_rst_b)
			map_r <= '0;
		else if (i_set && (32'(i_set_chan) < NCHAN))
			map_r[i_set_chan] <= i_set_val;
	end
endmodule
`default_nettype wire

//--- spmb_top_chk.sv
// spmb_top_chk: port assertions for the slave port mailbox
// assumes: bound to spmb_top; one clock, pins settle long before edges
`timescale 1ns/1ps
`default_nettype none
module spmb_top_chk (
	input wire logic       i_clk,
	input wire logic       i_rst_b,
	input wire logic       o_port_data_oe_b,
	input wire logic       i_port_select_n,
	input wire logic       i_port_select_alt_n,
	input wire logic       i_port_write_strobe_n,
	input wire logic       i_port_read_strobe_n,
	input wire logic       i_reg_addr_bit0,
	input wire logic       i_reg_addr_bit1,
	input wire logic       o_attention_pin_n,
	input wire logic       i_cpu_wr,
	input wire logic [7:0] i_cpu_addr,
	input wire logic       o_cmd_pending,
	input wire logic       o_cmd_dispatch,
	input wire logic       o_cmd_unhandled
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rst_b);
	wire sel = !(i_port_select_n && i_port_select_alt_n);
	wire rsp = i_cpu_wr && i_cpu_addr == 8'h20;
	wire a3 = i_reg_addr_bit1 && i_reg_addr_bit0;
	wire a0 = !i_reg_addr_bit1 && !i_reg_addr_bit0;
	property p_att_set;
		rsp |=> !o_attention_pin_n;
	endproperty
	a_att_set: assert property (p_att_set) else $error("attention late");
	// commit is two sync flops plus one, clear on that same edge
	property p_att_clr;
		$rose(i_port_write_strobe_n) && $past(sel && a3) |-> ##[2:6] o_attention_pin_n;
	endproperty
	a_att_clr: assert property (p_att_clr) else $error("attention kept");
	property p_pend_set;
		$rose(i_port_write_strobe_n) && $past(sel && a0) |-> ##[2:6] o_cmd_pending;
	endproperty
	a_pend_set: assert property (p_pend_set) else $error("no pending");
	property p_pend_clr;
		rsp |=> !o_cmd_pending;
	endproperty
	a_pend_clr: assert property (p_pend_clr) else $error("pending kept");
	property p_one;
		o_cmd_dispatch || o_cmd_unhandled |=> !o_cmd_dispatch && !o_cmd_unhandled;
	endproperty
	a_one: assert property (p_one) else $error("double dispatch");
	property p_excl;
		o_cmd_dispatch || o_cmd_unhandled |-> o_cmd_pending && !(o_cmd_dispatch && o_cmd_unhandled);
	endproperty
	a_excl: assert property (p_excl) else $error("both dispatch kinds");
	property p_oe_rd;
		(sel && !i_port_read_strobe_n && i_port_write_strobe_n)[*5] |-> !o_port_data_oe_b;
	endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("bus not driven");
	property p_nosel;
		(!sel)[*5] |-> o_port_data_oe_b;
	endproperty
	a_nosel: assert property (p_nosel) else $error("bus driven unselected");
endmodule
bind spmb_top spmb_top_chk u_chk (.*);
`default_nettype wire

//--- spmb_mst.sv
// spmb_mst: behavioural master controller on the slave port pins
// assumes: bench calls wr and rd; control pins move on falling edges, o_bus also on rising edges when the DUT drive changes
`timescale 1ns/1ps
`default_nettype none
module spmb_mst (
	input  wire logic       i_clk,
	input  wire logic [7:0] i_dut_data,
	input  wire logic       i_dut_oe_b,
	output logic      [7:0] o_bus,
	output logic            o_cs_n,
	output logic            o_cs_alt_n,
	output logic            o_wr_n,
	output logic            o_rd_n,
	output logic      [1:0] o_addr
);
	logic [7:0] d = 8'h00;
	logic       en = 1'b0;
	logic       alt = 1'b0;
	// a released bus shows the inverted last byte, so stale data is caught
	assign o_bus = !i_dut_oe_b ? i_dut_data : (en ? d : ~d);
	initial
	begin
		o_cs_n = 1'b1;
		o_cs_alt_n = 1'b1;
		o_wr_n = 1'b1;
		o_rd_n = 1'b1;
		o_addr = 2'h0;
	end
	task go(input logic [1:0] a);
		@(negedge i_clk);
		o_addr = a;
		if (alt) o_cs_alt_n = 1'b0;
		else o_cs_n = 1'b0;
	endtask
	task stop;
		o_cs_n = 1'b1;
		o_cs_alt_n = 1'b1;
		en = 1'b0;
		repeat (6) @(negedge i_clk);
	endtask
	task wr(input logic [1:0] a, input logic [7:0] v);
		go(a);
		d = v;
		en = 1'b1;
		o_wr_n = 1'b0;
		repeat (4) @(negedge i_clk);
		o_wr_n = 1'b1;
		stop;
	endtask
	task rd(input logic [1:0] a, output logic [7:0] v);
		go(a);
		o_rd_n = 1'b0;
		repeat (5) @(negedge i_clk);
		v = o_bus;
		o_rd_n = 1'b1;
		stop;
	endtask
endmodule
`default_nettype wire

//--- spmb_top_tb.sv
// spmb_top_tb: self-checking bench for the slave port mailbox
// assumes: spmb_mst plays the master; processor side driven here
`timescale 1ns/1ps
`default_nettype none
module spmb_top_tb;
	logic       i_clk;
	logic       i_rst_b;
	logic       i_cpu_wr;
	logic       i_cpu_rd;
	logic       i_handler_set;
	logic       i_handler_en;
	logic [7:0] i_cpu_addr;
	logic [7:0] i_cpu_wdata;
	logic [7:0] i_handler_chan;
	logic [7:0] v;
	int         bad_count = 0;
	int         samples_checked = 0;
	int         nd = 0;
	int         nu = 0;
	wire  [7:0] i_port_data, o_port_data, o_cpu_rdata;
	wire        i_port_select_n, i_port_select_alt_n, i_port_write_strobe_n;
	wire        i_port_read_strobe_n, i_reg_addr_bit0, i_reg_addr_bit1, o_port_data_oe_b;
	wire        o_attention_pin_n, o_attention_out_n, o_cmd_pending, o_cmd_dispatch;
	wire        o_cmd_unhandled;
	spmb_top dut (.*);
	spmb_mst m (.i_clk(i_clk), .i_dut_data(o_port_data), .i_dut_oe_b(o_port_data_oe_b),
		.o_bus(i_port_data), .o_cs_n(i_port_select_n), .o_cs_alt_n(i_port_select_alt_n),
		.o_wr_n(i_port_write_strobe_n), .o_rd_n(i_port_read_strobe_n),
		.o_addr({i_reg_addr_bit1, i_reg_addr_bit0}));
	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	always @(negedge i_clk)
	begin
		if (o_cmd_dispatch === 1'b1) nd++;
		if (o_cmd_unhandled === 1'b1) nu++;
	end
	task chk(input logic [7:0] g, input logic [7:0] e);
		samples_checked++;
		if (g !== e)
		begin
			bad_count++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task cw(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_cpu_addr = a;
		i_cpu_wdata = d;
		i_cpu_wr = 1'b1;
		@(negedge i_clk);
		i_cpu_wr = 1'b0;
	endtask
	task cr(input logic [7:0] a, input logic [7:0] e);
		@(negedge i_clk);
		i_cpu_addr = a;
		i_cpu_rd = 1'b1;
		@(negedge i_clk);
		i_cpu_rd = 1'b0;
		@(negedge i_clk);
		chk(o_cpu_rdata, e);
	endtask
	task mr(input logic [1:0] a, input logic [7:0] e);
		m.rd(a, v);
		chk(v, e);
	endtask
	task t_reset;
		chk(8'(o_attention_pin_n), 8'h01);
		chk(8'(o_port_data_oe_b), 8'h01);
		chk(8'(o_cmd_pending), 8'h00);
		chk(o_cpu_rdata, 8'h00);
		mr(2'h3, 8'h00);
	endtask
	task t_cmd;
		@(negedge i_clk);
		i_handler_chan = 8'h05;
		i_handler_en = 1'b1;
		i_handler_set = 1'b1;
		@(negedge i_clk);
		i_handler_set = 1'b0;
		m.wr(2'h1, 8'h05);
		m.wr(2'h2, 8'ha5);
		m.wr(2'h0, 8'h3c);
		chk(8'(nd), 8'h01);
		chk(8'(o_cmd_pending), 8'h01);
		mr(2'h3, 8'h07);
		mr(2'h0, 8'h00);
		mr(2'h2, 8'h00);
		cr(8'h20, 8'h3c);
		cr(8'h21, 8'h05);
		cr(8'h22, 8'ha5);
	endtask
	task t_resp;
		cw(8'h22, 8'h5a);
		cw(8'h20, 8'h81);
		chk(8'(o_attention_pin_n), 8'h00);
		chk(8'(o_cmd_pending), 8'h00);
		cw(8'h21, 8'hff);
		cr(8'h21, 8'h05);
		mr(2'h3, 8'h0e);
		mr(2'h0, 8'h81);
		mr(2'h2, 8'h5a);
		mr(2'h1, 8'h00);
		m.wr(2'h3, 8'h00);
		chk(8'(o_attention_pin_n), 8'h01);
		mr(2'h3, 8'h06);
	endtask
	task t_alt;
		m.alt = 1'b1;
		m.wr(2'h1, 8'h09);
		m.wr(2'h0, 8'h01);
		m.alt = 1'b0;
		chk(8'(nu), 8'h01);
		chk(8'(nd), 8'h01);
		mr(2'h0, 8'h81);
		cw(8'h20, 8'h02);
		chk(8'(o_attention_out_n), 8'h00);
		m.wr(2'h3, 8'hff);
		chk(8'(o_attention_out_n), 8'h01);
	endtask
	task stop_test;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial
	begin
		i_rst_b = 1'b0;
		i_cpu_wr = 1'b0;
		i_cpu_rd = 1'b0;
		i_handler_set = 1'b0;
		i_handler_en = 1'b0;
		i_cpu_addr = 8'h00;
		i_cpu_wdata = 8'h00;
		i_handler_chan = 8'h00;
		repeat (12) @(negedge i_clk);
		i_rst_b = 1'b1;
		t_reset;
		t_cmd;
		t_resp;
		t_alt;
		stop_test;
	end
	// about 230 cycles are needed; the 5000-cycle limit, over twenty times that, means a hang
	initial
	begin
		#200000;
		bad_count++;
		stop_test;
	end
endmodule
`default_nettype wire
